/* sim/host_model.sv */
// Purpose: Host side that sends request reports and captures replies
// Assumes: Requests sent only while the responder is idle
// Notes:   Released data line shows the inverse of its last byte
`timescale 1ns/1ps
module host_model
(
  input  wire logic                       core_clk,
  input  wire readback_pkg::report_byte_s rsp_out,
  output readback_pkg::report_byte_s      req_in
);
  logic [7:0] reply [64];
  int         n_rx = 0;
  initial req_in = '0;
  always @(posedge core_clk)
  begin
    if (rsp_out.valid === 1'b1)
    begin
      reply[n_rx % 64] = rsp_out.data;
      n_rx++;
    end
  end
  task automatic send(input logic [7:0] cmd, input logic [7:0] sub,
                      input int len);
    for (int i = 0; i < len; i++)
    begin
      @(posedge core_clk);
      req_in <= '{1'b1, i == len - 1,
                  i == 0 ? cmd : i == 1 ? sub : 8'h00};
    end
    @(posedge core_clk);
    req_in <= '{1'b0, 1'b0, ~req_in.data};
  endtask
endmodule

/* sim/readback_properties.sv */
// Purpose: Port-level assertions for the settings read-back responder
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Reply byte index is counted from rsp_out.valid
`timescale 1ns/1ps
module readback_properties
(
  input wire logic                         core_clk,
  input wire logic                         sys_rst,
  input wire readback_pkg::report_byte_s   req_in,
  input wire readback_pkg::chip_settings_s chip_cfg,
  input wire readback_pkg::key_params_s    key_cfg,
  input wire readback_pkg::report_byte_s   rsp_out,
  input wire logic                         busy,
  input wire logic                         bad_request
);
  logic [5:0] idx_r;
  logic [7:0] sub_r;
  logic       chip;
  logic       key;
  logic [7:0] d;
  logic [2:0] mode;
  logic [1:0] prot;
  assign d    = rsp_out.data;
  assign chip = rsp_out.valid && sub_r == readback_pkg::SUB_CHIP;
  assign key  = rsp_out.valid && sub_r == readback_pkg::SUB_KEY;
  // Reserved pulse-counting modes read back as none
  assign mode = chip_cfg.count_mode > 3'h4 ? 3'h0 : chip_cfg.count_mode;
  assign prot = chip_cfg.protection;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      idx_r <= 6'h00;
      sub_r <= 8'h00;
    end
    else if (rsp_out.valid)
    begin
      idx_r <= rsp_out.last ? 6'h00 : idx_r + 6'h01;
      if (idx_r == 6'h02)
        sub_r <= d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_cmd_echo: assert property (rsp_out.valid && idx_r == 6'h00 |-> d == 8'h61)
    else $error("reply byte 0 is not the command code");
  a_last_flag: assert property (rsp_out.valid |->
    rsp_out.last == (idx_r == 6'h3F))
    else $error("reply last flag not on byte 63");
  a_status_ok: assert property (rsp_out.valid && idx_r == 6'h01 |-> d == 8'h00)
    else $error("reply byte 1 is not success");
  a_sub_echo: assert property (rsp_out.valid && idx_r == 6'h02 |->
    d inside {8'h20, 8'h30})
    else $error("reply byte 2 is not a sub-command echo");
  a_pin7_role: assert property (chip && idx_r == 6'h0B |->
    d == {6'h00, chip_cfg.pin_roles[15:14]})
    else $error("pin seven code wrong");
  a_input_pin: assert property (chip && idx_r == 6'h0C |->
    d == {6'h00, chip_cfg.input_only_pin_dedicated, 1'b0})
    else $error("input-only pin code wrong");
  a_out_word: assert property (chip && idx_r == 6'h0D |->
    d == chip_cfg.default_output ##1 d == 8'h00)
    else $error("default output word wrong");
  a_dir_word: assert property (chip && idx_r == 6'h0F |->
    d == chip_cfg.default_direction ##1 d == 8'h00)
    else $error("default direction word wrong");
  a_option_bits: assert property (chip && idx_r == 6'h11 |-> d ==
    {3'h0, chip_cfg.remote_wakeup, mode, chip_cfg.spi_bus_hold})
    else $error("option byte wrong");
  a_prot_code: assert property (chip && idx_r == 6'h12 |->
    d == {prot == 2'h2, prot == 2'h1, 6'h00})
    else $error("protection byte wrong");
  a_vendor_id: assert property (key && idx_r == 6'h0C |->
    d == key_cfg.vendor_id[7:0] ##1 d == key_cfg.vendor_id[15:8]
    ##1 d == key_cfg.product_id[7:0] ##1 d == key_cfg.product_id[15:8])
    else $error("vendor or product id wrong");
  a_power_bits: assert property (key && idx_r == 6'h1D |-> d[7:5] ==
    {key_cfg.bus_powered, key_cfg.self_powered, key_cfg.wakeup_capable}
    ##1 d == key_cfg.current_units)
    else $error("power or current byte wrong");
endmodule
bind settings_readback_responder readback_properties readback_properties_inst
(
  .core_clk(core_clk), .sys_rst(sys_rst), .req_in(req_in),
  .chip_cfg(chip_cfg), .key_cfg(key_cfg), .rsp_out(rsp_out),
  .busy(busy), .bad_request(bad_request)
);

/* sim/test_settings_readback_responder.sv */
// Purpose: Self-checking bench for the settings read-back responder
// Assumes: 50 MHz clock, reset held for eight cycles
// Notes:   Replies are judged from the host model's capture
`timescale 1ns/1ps
module test_settings_readback_responder;
  logic                         core_clk = 1'b0;
  logic                         sys_rst  = 1'b1;
  readback_pkg::report_byte_s   req_in;
  readback_pkg::report_byte_s   rsp_out;
  readback_pkg::chip_settings_s chip_cfg = '0;
  readback_pkg::key_params_s    key_cfg  = '0;
  logic                         busy;
  logic                         bad_request;
  int                           n_errors = 0;
  int                           n_tests  = 0;
  int                           n_bad    = 0;
  int                           cycles   = 0;
  always #10 core_clk = ~core_clk;
  settings_readback_responder settings_readback_responder_inst
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .req_in(req_in),
    .chip_cfg(chip_cfg), .key_cfg(key_cfg), .rsp_out(rsp_out),
    .busy(busy), .bad_request(bad_request)
  );
  host_model host_model_inst
  (
    .core_clk(core_clk), .rsp_out(rsp_out), .req_in(req_in)
  );
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] cmd, input logic [7:0] sub,
                     input int len, input int want);
    int base;
    int bad0;
    base = host_model_inst.n_rx;
    bad0 = n_bad;
    host_model_inst.send(cmd, sub, len);
    for (int i = 0; i < 200 && host_model_inst.n_rx < base + want; i++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    check(8'(host_model_inst.n_rx - base), 8'(want));
    check({7'h00, busy}, 8'h00);
    check(8'(n_bad - bad0), want == 0 ? 8'h01 : 8'h00);
  endtask
  task automatic chip_case(input logic [2:0] k);
    logic [1:0] r;
    r = 2'(k % 3);
    chip_cfg <= '{{r, 14'h0924}, k[0], 8'hA5 ^ {5'h00, k}, 8'h3C + k,
                  k[1], k, k[2], readback_pkg::prot_level_e'(r)};
    run(8'h61, 8'h20, 64, 64);
    check(host_model_inst.reply[0], 8'h61);
    check(host_model_inst.reply[1], 8'h00);
    check(host_model_inst.reply[2], 8'h20);
    for (int i = 0; i < 8; i++)
      check(host_model_inst.reply[4 + i],
            {6'h00, chip_cfg.pin_roles[2 * i +: 2]});
    check(host_model_inst.reply[12], {6'h00, k[0], 1'b0});
    check(host_model_inst.reply[13], 8'hA5 ^ {5'h00, k});
    check(host_model_inst.reply[14], 8'h00);
    check(host_model_inst.reply[15], 8'h3C + k);
    check(host_model_inst.reply[16], 8'h00);
    check(host_model_inst.reply[17],
          {3'h0, k[1], k > 3'h4 ? 3'h0 : k, k[2]});
    check(host_model_inst.reply[18],
          r == 2'h2 ? 8'h80 : r == 2'h1 ? 8'h40 : 8'h00);
  endtask
  task automatic key_case(input logic v);
    key_cfg <= '{16'h1234 ^ {16{v}}, 16'hBEEF ^ {16{v}}, v, ~v, v,
                 v ? 8'hFA : 8'h32};
    run(8'h61, 8'h30, 64, 64);
    check(host_model_inst.reply[2], 8'h30);
    check(host_model_inst.reply[12], 8'h34 ^ {8{v}});
    check(host_model_inst.reply[13], 8'h12 ^ {8{v}});
    check(host_model_inst.reply[14], 8'hEF ^ {8{v}});
    check(host_model_inst.reply[15], 8'hBE ^ {8{v}});
    check(host_model_inst.reply[29][7:5], {v, ~v, v});
    check(host_model_inst.reply[30], v ? 8'hFA : 8'h32);
  endtask
  task automatic bad_case();
    run(8'h61, 8'h50, 64, 0);
    run(8'h70, 8'h20, 64, 0);
    run(8'h61, 8'h20, 10, 0);
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (bad_request === 1'b1)
      n_bad++;
    if (cycles == 10000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check({5'h00, busy, bad_request, rsp_out.valid}, 8'h00);
    for (int k = 0; k < 8; k++)
      chip_case(3'(k));
    key_case(1'b0);
    key_case(1'b1);
    bad_case();
    complete_run();
  end
endmodule

/* verilog/readback_pkg.sv */
// Purpose: Constants and carriers for the settings read-back responder
// Assumes: 64-byte reports handled one byte per clock
// Notes:   Key reply bytes 12-15 hold vendor then product ID, low byte first; other unlisted reply bytes read as zero
// Functional notes
// - Chip settings reply: command code, success, sub-command 0x20 in bytes 0-2.
// - Bytes 4-11 carry pin zero..seven designations, byte 12 the input-only pin: 00 I/O, 01 select, 02 dedicated.
// - Bytes 13-14 default output word, low byte first, bit n is pin n.
// - Bytes 15-16 default direction word, low byte first, bit n is pin n.
// - Byte 17 bit 4 reports remote wake-up enable; bits 7-5 don't care.
// - Byte 17 bits 3-1 hold pulse-counting mode; codes 101-111 reserved.
// - Byte 17 bit 0: 0 releases SPI bus between transfers, 1 keeps it.
// - Byte 18 protection level: 00 open, 40 password, 80 locked.
// - Every read-back reply echoes the received command code in byte 0.
// - Byte 1 of a read-back reply is 0x00 for success.
// - Key-parameters reply echoes 0x30 in byte 2; listed spans don't care.
// - Byte 29 power attributes: bit 7 bus, 6 self, 5 wake-up capable.
// - Byte 30 requested current in 2 mA units.
package readback_pkg;
  localparam logic [7:0] CMD_READBACK   = 8'h61;
  localparam logic [7:0] SUB_CHIP       = 8'h20;
  localparam logic [7:0] SUB_KEY        = 8'h30;
  localparam logic [7:0] STATUS_OK      = 8'h00;
  localparam logic [5:0] LAST_BYTE      = 6'h3F;
  localparam logic [5:0] B_CMD          = 6'h00;
  localparam logic [5:0] B_STATUS       = 6'h01;
  localparam logic [5:0] B_SUB          = 6'h02;
  localparam logic [5:0] B_PIN0         = 6'h04;
  localparam logic [5:0] B_PIN7         = 6'h0B;
  localparam logic [5:0] B_INPIN        = 6'h0C;
  localparam logic [5:0] B_OUT_LO       = 6'h0D;
  localparam logic [5:0] B_OUT_HI       = 6'h0E;
  localparam logic [5:0] B_DIR_LO       = 6'h0F;
  localparam logic [5:0] B_DIR_HI       = 6'h10;
  localparam logic [5:0] B_OPTS         = 6'h11;
  localparam logic [5:0] B_PROT         = 6'h12;
  localparam logic [5:0] B_VID_LO       = 6'h0C;
  localparam logic [5:0] B_VID_HI       = 6'h0D;
  localparam logic [5:0] B_PID_LO       = 6'h0E;
  localparam logic [5:0] B_PID_HI       = 6'h0F;
  localparam logic [5:0] B_POWER        = 6'h1D;
  localparam logic [5:0] B_CURRENT      = 6'h1E;
  localparam logic [7:0] PIN_GPIO       = 8'h00;
  localparam logic [7:0] PIN_SELECT     = 8'h01;
  localparam logic [7:0] PIN_DEDICATED  = 8'h02;
  localparam logic [7:0] PROT_OPEN      = 8'h00;
  localparam logic [7:0] PROT_PASSWORD  = 8'h40;
  localparam logic [7:0] PROT_LOCKED    = 8'h80;
  localparam int         OPT_WAKE_BIT   = 4;
  localparam int         OPT_MODE_LSB   = 1;
  localparam int         OPT_HOLD_BIT   = 0;
  localparam int         PWR_BUS_BIT    = 7;
  localparam int         PWR_SELF_BIT   = 6;
  localparam int         PWR_WAKE_BIT   = 5;
  localparam logic [2:0] MODE_MAX       = 3'h4;

  typedef enum logic [1:0] {
    PIN_IO  = 2'b00,
    PIN_CS  = 2'b01,
    PIN_DED = 2'b10
  } pin_role_e;

  typedef enum logic [1:0] {
    LVL_OPEN     = 2'b00,
    LVL_PASSWORD = 2'b01,
    LVL_LOCKED   = 2'b10
  } prot_level_e;

  // Stored power-up chip settings
  typedef struct packed {
    logic [15:0]       pin_roles;
    logic              input_only_pin_dedicated;
    logic [7:0]        default_output;
    logic [7:0]        default_direction;
    logic              remote_wakeup;
    logic [2:0]        count_mode;
    logic              spi_bus_hold;
    prot_level_e       protection;
  } chip_settings_s;

  // Stored USB key parameters
  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic        bus_powered;
    logic        self_powered;
    logic        wakeup_capable;
    logic [7:0]  current_units;
  } key_params_s;

  // One report byte on its way in or out
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } report_byte_s;
endpackage

/* verilog/report_buffer.sv */
// Purpose: 64-byte report store with registered read data
// Assumes: One write and one read per clock, same clock
// Notes:   Read data appear one clock after the address
`timescale 1ns/1ps
module report_buffer
(
  input  wire logic       core_clk,
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [64];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* verilog/settings_readback_responder.sv */
// Purpose: Answers power-up chip settings and USB key parameter requests
// Assumes: Request and reply bytes stream one per clock, byte 0 first
// Notes:   Other requests are swallowed without a reply
`timescale 1ns/1ps
module settings_readback_responder
(
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire readback_pkg::report_byte_s  req_in,
  input  wire readback_pkg::chip_settings_s chip_cfg,
  input  wire readback_pkg::key_params_s   key_cfg,
  output readback_pkg::report_byte_s       rsp_out,
  output logic                             busy,
  output logic                             bad_request
);
  typedef enum logic [1:0] {
    ST_RECV  = 2'b00,
    ST_FETCH = 2'b01,
    ST_SEND  = 2'b10
  } state_e;

  typedef struct packed {
    state_e                     st;
    logic [5:0]                 idx;
    logic [7:0]                 cmd;
    logic [7:0]                 sub;
    logic                       ok;
    logic                       pad_err;
    logic                       rd_ok;
    logic [5:0]                 rd_idx;
    readback_pkg::report_byte_s rsp;
    logic                       busy;
    logic                       bad;
  } state_s;

  state_s     s_r;
  state_s     s_nxt;
  logic [7:0] reply_byte;
  logic [7:0] buf_rd;

  function automatic logic [7:0] role_code(input logic [1:0] r);
    case (r)
      readback_pkg::PIN_CS:  role_code = readback_pkg::PIN_SELECT;
      readback_pkg::PIN_DED: role_code = readback_pkg::PIN_DEDICATED;
      default:               role_code = readback_pkg::PIN_GPIO;
    endcase
  endfunction

  function automatic logic [7:0] prot_code(input logic [1:0] p);
    case (p)
      readback_pkg::LVL_PASSWORD: prot_code = readback_pkg::PROT_PASSWORD;
      readback_pkg::LVL_LOCKED:   prot_code = readback_pkg::PROT_LOCKED;
      default:                    prot_code = readback_pkg::PROT_OPEN;
    endcase
  endfunction

  // Reply builder for the byte being written into the buffer
  always_comb
  begin
    logic [2:0] mode;
    logic [6:0] pin_off;
    mode       = chip_cfg.count_mode;
    pin_off    = 7'(s_r.idx) - 7'(readback_pkg::B_PIN0);
    reply_byte = 8'h00;
    if (mode > readback_pkg::MODE_MAX)
    begin
      mode = 3'h0;
    end
    if (s_r.idx == readback_pkg::B_CMD)
    begin
      reply_byte = s_r.cmd;
    end
    else if (s_r.idx == readback_pkg::B_STATUS)
    begin
      reply_byte = readback_pkg::STATUS_OK;
    end
    else if (s_r.idx == readback_pkg::B_SUB)
    begin
      reply_byte = s_r.sub;
    end
    else if (s_r.sub == readback_pkg::SUB_CHIP)
    begin
      if (s_r.idx >= readback_pkg::B_PIN0 && s_r.idx <= readback_pkg::B_PIN7)
      begin
        reply_byte = role_code(chip_cfg.pin_roles[{pin_off[2:0], 1'b0} +: 2]);
      end
      else if (s_r.idx == readback_pkg::B_INPIN)
      begin
        reply_byte = chip_cfg.input_only_pin_dedicated ?
                     readback_pkg::PIN_DEDICATED :
                     readback_pkg::PIN_GPIO;
      end
      else if (s_r.idx == readback_pkg::B_OUT_LO)
      begin
        reply_byte = chip_cfg.default_output;
      end
      else if (s_r.idx == readback_pkg::B_DIR_LO)
      begin
        reply_byte = chip_cfg.default_direction;
      end
      else if (s_r.idx == readback_pkg::B_OPTS)
      begin
        reply_byte[readback_pkg::OPT_WAKE_BIT] = chip_cfg.remote_wakeup;
        reply_byte[readback_pkg::OPT_MODE_LSB +: 3] = mode;
        reply_byte[readback_pkg::OPT_HOLD_BIT] = chip_cfg.spi_bus_hold;
      end
      else if (s_r.idx == readback_pkg::B_PROT)
      begin
        reply_byte = prot_code(chip_cfg.protection);
      end
    end
    else
    begin
      case (s_r.idx)
        readback_pkg::B_VID_LO: reply_byte = key_cfg.vendor_id[7:0];
        readback_pkg::B_VID_HI: reply_byte = key_cfg.vendor_id[15:8];
        readback_pkg::B_PID_LO: reply_byte = key_cfg.product_id[7:0];
        readback_pkg::B_PID_HI: reply_byte = key_cfg.product_id[15:8];
        readback_pkg::B_POWER:
        begin
          reply_byte[readback_pkg::PWR_BUS_BIT]  = key_cfg.bus_powered;
          reply_byte[readback_pkg::PWR_SELF_BIT] = key_cfg.self_powered;
          reply_byte[readback_pkg::PWR_WAKE_BIT] = key_cfg.wakeup_capable;
        end
        readback_pkg::B_CURRENT: reply_byte = key_cfg.current_units;
        default: reply_byte = 8'h00;
      endcase
    end
  end

  // Sequencer: receive request, fill buffer, stream reply
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.valid = 1'b0;
    s_nxt.rsp.last  = 1'b0;
    s_nxt.bad       = 1'b0;
    s_nxt.rd_ok     = 1'b0;
    case (s_r.st)
      ST_RECV:
      begin
        if (req_in.valid)
        begin
          if (s_r.idx == readback_pkg::B_CMD)
          begin
            s_nxt.cmd     = req_in.data;
            s_nxt.pad_err = 1'b0;
          end
          else if (s_r.idx == readback_pkg::B_STATUS)
          begin
            s_nxt.sub = req_in.data;
          end
          else if (req_in.data != 8'h00)
          begin
            s_nxt.pad_err = 1'b1;
          end
          s_nxt.idx = s_r.idx + 6'h01;
          if (req_in.last || s_r.idx == readback_pkg::LAST_BYTE)
          begin
            s_nxt.idx = 6'h00;
            // Only a full 64-byte request of a known kind is answered
            s_nxt.ok  = s_r.idx == readback_pkg::LAST_BYTE &&
                        s_r.cmd == readback_pkg::CMD_READBACK &&
                        (s_r.sub == readback_pkg::SUB_CHIP ||
                         s_r.sub == readback_pkg::SUB_KEY);
            if (s_nxt.ok)
            begin
              s_nxt.st   = ST_FETCH;
              s_nxt.busy = 1'b1;
            end
            else
            begin
              s_nxt.bad = 1'b1;
            end
          end
        end
      end
      ST_FETCH:
      begin
        s_nxt.idx = s_r.idx + 6'h01;
        if (s_r.idx == readback_pkg::LAST_BYTE)
        begin
          s_nxt.st    = ST_SEND;
          s_nxt.idx   = 6'h00;
          // Buffer read data lag the address by one clock
          s_nxt.rd_ok = 1'b0;
        end
      end
      ST_SEND:
      begin
        s_nxt.rd_ok  = 1'b1;
        s_nxt.rd_idx = s_r.idx;
        s_nxt.idx    = s_r.idx + 6'h01;
        if (s_r.rd_ok)
        begin
          s_nxt.rsp.valid = 1'b1;
          s_nxt.rsp.data  = buf_rd;
          s_nxt.rsp.last  = s_r.rd_idx == readback_pkg::LAST_BYTE;
        end
        if (s_r.rd_idx == readback_pkg::LAST_BYTE && s_r.rd_ok)
        begin
          s_nxt.st    = ST_RECV;
          s_nxt.idx   = 6'h00;
          s_nxt.rd_ok = 1'b0;
          s_nxt.busy  = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  report_buffer report_buffer_inst
  (
    .core_clk (core_clk),
    .wr_en    (s_r.st == ST_FETCH),
    .wr_addr  (s_r.idx),
    .wr_data  (reply_byte),
    .rd_addr  (s_r.idx),
    .rd_data  (buf_rd)
  );

  assign rsp_out     = s_r.rsp;
  assign busy        = s_r.busy;
  assign bad_request = s_r.bad;
endmodule
